// [design/bhht_pkg.sv]
// Package for the instrument-bus byte handshake block: register map, field positions, resets.
// Assumes an AXI4-Lite master with 32-bit data reaches the registers in one aligned word each.
package bhht_pkg;
	// ==========================================================================
	// Register byte addresses
	localparam logic [7:0] ADDR_INT_STATUS = 8'h00; // interrupt_status_read
	localparam logic [7:0] ADDR_INT_MASK = 8'h04; // interrupt_mask_write
	localparam logic [7:0] ADDR_ADDR_MODE = 8'h08; // address_mode_write
	localparam logic [7:0] ADDR_HS_STATUS = 8'h0c; // handshake_line_status
	localparam logic [7:0] ADDR_AUX_CMD = 8'h10; // auxiliary_command_write
	localparam logic [7:0] ADDR_DATA = 8'h14; // data_in_register / data_out_register
	// ==========================================================================
	// Field positions
	localparam int ST_BYTE_RECEIVED = 0;
	localparam int ST_BYTE_SENT = 1;
	localparam int ST_END = 2;
	localparam int ST_CMD_BYTE = 3;
	localparam int MODE_HOLD_ALL = 0;
	localparam int MODE_HOLD_END = 1;
	localparam int MODE_TALK_ONLY = 2;
	localparam int MODE_LISTEN_ONLY = 3;
	localparam int AUX_ACCEPT_RELEASE = 0;
	localparam int AUX_READY_RELEASE = 1;
	localparam int HS_VALID = 0;
	localparam int HS_READY = 1;
	localparam int HS_ACCEPTED = 2;
	localparam int HS_ATTENTION = 3;
	// ==========================================================================
	// Reset values and bus responses
	localparam logic [1:0] MASK_RESET = 2'h0;
	localparam logic [3:0] MODE_RESET = 4'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [design/bhht_top.sv]
// Byte handshake block: source and acceptor handshakes, hold-off modes, AXI4-Lite registers.
// Bus lines are active high here (true = asserted); the pad layer does inversion and drive.
// Handshake inputs come from the bus asynchronously and are synchronised inside.
// How it works
// - Reading data-in clears byte-received flag.
// - Listener data-in read releases data-accepted line.
// - Accept-release command acts like a data-in read.
// - Hold-all keeps ready low after every byte.
// - Hold-end holds ready only after end byte.
// - Ready-release ends hold-off; otherwise ready stays low.
// - Held-off ready blocks any new transfer cycle.
// - Byte-sent sets when all acceptors accepted.
// - Talk-only sends data-out writes without addressing unless listen-only is set.
// - Listen-only accepts bus bytes without addressing.
// - Handshake line levels readable by host.
// - Interrupt raised only for unmasked status events.
// - Attention marks a byte as a command.
// - Byte-received means data present; clear keeps it.
// - Data-in latches inverted lines while valid high.
// - Pending new byte survives clear and roles.
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module bhht_top (
	// Clock, reset and clock enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// AXI4-Lite write channels
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Instrument bus, levels already inverted to active high
	input wire logic [7:0] bus_data_low_in,
	input wire logic bus_valid_in,
	input wire logic bus_ready_in,
	input wire logic bus_accepted_in,
	input wire logic bus_attention_in,
	input wire logic bus_end_in,
	output logic [7:0] bus_data_out,
	output logic bus_data_oe,
	output logic bus_valid_out,
	output logic bus_ready_out,
	output logic bus_accepted_out,
	// Host interrupt
	output logic irq
);
	// ==========================================================================
	// Synchronisers
	logic [3:0] sync1;
	logic [3:0] sync2;
	logic [3:0] next_sync1;
	logic [3:0] next_sync2;
	always_comb begin
		next_sync1 = {bus_attention_in, bus_accepted_in, bus_ready_in, bus_valid_in};
		next_sync2 = sync1;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
		end else if (ce) begin
			sync1 <= next_sync1;
			sync2 <= next_sync2;
		end
	end
	wire logic valid_s = sync2[0];
	wire logic ready_s = sync2[1];
	wire logic accepted_s = sync2[2];
	wire logic attention_s = sync2[3];
	// ==========================================================================
	// Acceptor (listener) and source (talker) state machines
	typedef enum logic [3:0] {
		ACC_IDLE = 4'b0001,
		ACC_READY = 4'b0010,
		ACC_HOLD = 4'b0100,
		ACC_WAIT_GONE = 4'b1000
	} bhht_acc_t;
	typedef enum logic [2:0] {
		SRC_IDLE = 3'b001,
		SRC_WAIT_READY = 3'b010,
		SRC_WAIT_ACCEPT = 3'b100
	} bhht_src_t;
	bhht_acc_t acc;
	bhht_acc_t next_acc;
	bhht_src_t src;
	bhht_src_t next_src;
	logic [3:0] mode;
	logic [1:0] mask;
	logic [3:0] status;
	logic [7:0] data_in;
	logic [7:0] data_out;
	logic pending;
	logic holdoff;
	logic [3:0] next_mode;
	logic [1:0] next_mask;
	logic [3:0] next_status;
	logic [7:0] next_data_in;
	logic [7:0] next_data_out;
	logic next_pending;
	logic next_holdoff;
	logic next_ready_out;
	logic next_accepted_out;
	logic next_valid_out;
	logic next_oe;
	// Register strobes from the bus slave.
	logic wr_fire;
	logic rd_fire;
	logic [7:0] wr_addr;
	logic [7:0] rd_addr;
	logic [31:0] wr_data;
	logic data_read;
	logic accept_release;
	logic ready_release;
	logic listening;
	logic talking;
	always_comb begin
		data_read = rd_fire && rd_addr == bhht_pkg::ADDR_DATA;
		accept_release = data_read ||
			(wr_fire && wr_addr == bhht_pkg::ADDR_AUX_CMD &&
			wr_data[bhht_pkg::AUX_ACCEPT_RELEASE]);
		ready_release = wr_fire && wr_addr == bhht_pkg::ADDR_AUX_CMD &&
			wr_data[bhht_pkg::AUX_READY_RELEASE];
		listening = mode[bhht_pkg::MODE_LISTEN_ONLY];
		talking = mode[bhht_pkg::MODE_TALK_ONLY] && !listening;
	end
	// Handshake next state; byte events set flags with priority over host clears.
	always_comb begin
		next_acc = acc;
		next_src = src;
		next_status = status;
		next_data_in = data_in;
		next_holdoff = holdoff;
		next_pending = pending;
		next_data_out = data_out;
		next_ready_out = 1'b0;
		next_accepted_out = 1'b0;
		next_valid_out = 1'b0;
		next_oe = 1'b0;
		if (data_read) begin
			next_status[bhht_pkg::ST_BYTE_RECEIVED] = 1'b0;
		end
		if (ready_release) begin
			next_holdoff = 1'b0;
		end
		if (wr_fire && wr_addr == bhht_pkg::ADDR_DATA) begin
			next_data_out = wr_data[7:0];
			next_pending = 1'b1;
			next_status[bhht_pkg::ST_BYTE_SENT] = 1'b0;
		end
		case (acc)
			ACC_IDLE: begin
				if (listening && !holdoff && !valid_s) begin
					next_acc = ACC_READY;
				end
			end
			ACC_READY: begin
				next_ready_out = !holdoff;
				if (!listening) begin
					next_acc = ACC_IDLE;
				end else if (valid_s) begin
					next_data_in = bus_data_low_in;
					next_status[bhht_pkg::ST_BYTE_RECEIVED] = 1'b1;
					next_status[bhht_pkg::ST_END] = bus_end_in;
					next_status[bhht_pkg::ST_CMD_BYTE] = attention_s;
					next_ready_out = 1'b0;
					if (mode[bhht_pkg::MODE_HOLD_ALL] ||
						(mode[bhht_pkg::MODE_HOLD_END] && bus_end_in)) begin
						next_holdoff = 1'b1;
					end
					next_acc = ACC_HOLD;
				end
			end
			ACC_HOLD: begin
				// Data-in keeps following the lines while valid stays asserted.
				if (valid_s) begin
					next_data_in = bus_data_low_in;
				end
				if (accept_release || !listening) begin
					next_accepted_out = 1'b1;
					next_acc = ACC_WAIT_GONE;
				end
			end
			ACC_WAIT_GONE: begin
				next_accepted_out = 1'b1;
				if (!valid_s) begin
					next_accepted_out = 1'b0;
					next_acc = ACC_IDLE;
				end
			end
			default: next_acc = ACC_IDLE;
		endcase
		case (src)
			SRC_IDLE: begin
				if (talking && pending) begin
					next_src = SRC_WAIT_READY;
				end
			end
			SRC_WAIT_READY: begin
				next_oe = 1'b1;
				if (!talking) begin
					next_oe = 1'b0;
					next_src = SRC_IDLE;
				end else if (ready_s && !accepted_s) begin
					next_valid_out = 1'b1;
					next_pending = 1'b0;
					next_src = SRC_WAIT_ACCEPT;
				end
			end
			SRC_WAIT_ACCEPT: begin
				next_oe = 1'b1;
				next_valid_out = 1'b1;
				if (accepted_s) begin
					next_status[bhht_pkg::ST_BYTE_SENT] = 1'b1;
					next_valid_out = 1'b0;
					next_src = SRC_IDLE;
				end
			end
			default: next_src = SRC_IDLE;
		endcase
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			acc <= ACC_IDLE;
			src <= SRC_IDLE;
			status <= 4'h0;
			data_in <= 8'h00;
			data_out <= 8'h00;
			pending <= 1'b0;
			holdoff <= 1'b0;
			bus_ready_out <= 1'b0;
			bus_accepted_out <= 1'b0;
			bus_valid_out <= 1'b0;
			bus_data_oe <= 1'b0;
			bus_data_out <= 8'h00;
		end else if (ce) begin
			acc <= next_acc;
			src <= next_src;
			status <= next_status;
			data_in <= next_data_in;
			data_out <= next_data_out;
			pending <= next_pending;
			holdoff <= next_holdoff;
			bus_ready_out <= next_ready_out;
			bus_accepted_out <= next_accepted_out;
			bus_valid_out <= next_valid_out;
			bus_data_oe <= next_oe;
			bus_data_out <= next_data_out;
		end
	end
	// ==========================================================================
	// AXI4-Lite slave: address and data taken in either order, one of each at a time.
	logic aw_held;
	logic w_held;
	logic [7:0] aw_q;
	logic [31:0] w_q;
	logic next_aw_held;
	logic next_w_held;
	logic [7:0] next_aw_q;
	logic [31:0] next_w_q;
	logic next_bvalid;
	logic [1:0] next_bresp;
	logic next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	logic next_irq;
	function automatic logic mapped(input logic [7:0] a);
		mapped = a == bhht_pkg::ADDR_INT_STATUS || a == bhht_pkg::ADDR_INT_MASK ||
			a == bhht_pkg::ADDR_ADDR_MODE || a == bhht_pkg::ADDR_HS_STATUS ||
			a == bhht_pkg::ADDR_AUX_CMD || a == bhht_pkg::ADDR_DATA;
	endfunction
	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_q = aw_q;
		next_w_q = w_q;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		next_mode = mode;
		next_mask = mask;
		wr_fire = 1'b0;
		rd_fire = 1'b0;
		wr_addr = aw_q;
		wr_data = w_q;
		rd_addr = s_axi_araddr;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_q = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_q = s_axi_wdata;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (aw_held && w_held && !s_axi_bvalid) begin
			wr_fire = mapped(aw_q);
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = mapped(aw_q) ? bhht_pkg::RESP_OKAY : bhht_pkg::RESP_SLVERR;
			if (aw_q == bhht_pkg::ADDR_INT_MASK) begin
				next_mask = w_q[1:0];
			end
			if (aw_q == bhht_pkg::ADDR_ADDR_MODE) begin
				next_mode = w_q[3:0];
			end
		end
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rd_fire = 1'b1;
			next_rvalid = 1'b1;
			next_rresp = bhht_pkg::RESP_OKAY;
			next_rdata = 32'h0000_0000;
			if (s_axi_araddr == bhht_pkg::ADDR_INT_STATUS) begin
				next_rdata = {28'h0000000, status};
			end else if (s_axi_araddr == bhht_pkg::ADDR_INT_MASK) begin
				next_rdata = {30'h00000000, mask};
			end else if (s_axi_araddr == bhht_pkg::ADDR_ADDR_MODE) begin
				next_rdata = {28'h0000000, mode};
			end else if (s_axi_araddr == bhht_pkg::ADDR_HS_STATUS) begin
				next_rdata = {28'h0000000, attention_s, accepted_s, ready_s, valid_s};
			end else if (s_axi_araddr == bhht_pkg::ADDR_DATA) begin
				next_rdata = {24'h000000, data_in};
			end else if (s_axi_araddr != bhht_pkg::ADDR_AUX_CMD) begin
				next_rresp = bhht_pkg::RESP_SLVERR;
			end
		end
		// Byte strobes are ignored: every register is narrower than one lane group.
		next_irq = |(status[1:0] & next_mask);
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_q <= 8'h00;
			w_q <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= bhht_pkg::RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= bhht_pkg::RESP_OKAY;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_arready <= 1'b0;
			mode <= bhht_pkg::MODE_RESET;
			mask <= bhht_pkg::MASK_RESET;
			irq <= 1'b0;
		end else if (ce) begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_q <= next_aw_q;
			w_q <= next_w_q;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
			s_axi_awready <= !next_aw_held && !next_bvalid;
			s_axi_wready <= !next_w_held && !next_bvalid;
			s_axi_arready <= !next_rvalid && !s_axi_arready;
			mode <= next_mode;
			mask <= next_mask;
			irq <= next_irq;
		end
	end
	// ==========================================================================
	// Checks
	property p_read_clears;
		@(posedge clk) disable iff (rst)
		ce && data_read && !(acc == ACC_READY && valid_s && listening)
		|=> !status[bhht_pkg::ST_BYTE_RECEIVED];
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("read kept byte flag");
	property p_release;
		@(posedge clk) disable iff (rst)
		ce && acc == ACC_HOLD && accept_release |=> bus_accepted_out;
	endproperty
	a_release: assert property (p_release) else $error("accepted not released");
	property p_hold_ready;
		@(posedge clk) disable iff (rst)
		holdoff |-> !bus_ready_out;
	endproperty
	a_hold_ready: assert property (p_hold_ready) else $error("ready during hold-off");
	property p_sent;
		@(posedge clk) disable iff (rst)
		ce && src == SRC_WAIT_ACCEPT && accepted_s |=> status[bhht_pkg::ST_BYTE_SENT];
	endproperty
	a_sent: assert property (p_sent) else $error("byte-sent not set");
	property p_irq;
		@(posedge clk) disable iff (rst)
		irq |-> $past(|(status[1:0])) || |(status[1:0]);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt without status");
	property p_pending;
		@(posedge clk) disable iff (rst)
		pending && !talking |=> pending;
	endproperty
	a_pending: assert property (p_pending) else $error("pending byte lost");
	property p_hold_all;
		@(posedge clk) disable iff (rst)
		ce && acc == ACC_READY && listening && valid_s && mode[bhht_pkg::MODE_HOLD_ALL]
		&& !ready_release |=> holdoff;
	endproperty
	a_hold_all: assert property (p_hold_all) else $error("hold-all missed");
	property p_rel;
		@(posedge clk) disable iff (rst)
		ce && ready_release && !(acc == ACC_READY && valid_s) |=> !holdoff;
	endproperty
	a_rel: assert property (p_rel) else $error("ready-release ignored");
endmodule
`default_nettype wire

// [verification/bhht_far.sv]
// Behavioural far side of the instrument bus: one talker and one listener.
// Assumes the active-high line levels that the block sees behind its pads.
`timescale 1ns/1ps
`default_nettype none
module bhht_far (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Test control
	input wire logic tx_req,
	input wire logic [7:0] tx_byte,
	input wire logic tx_end,
	input wire logic [3:0] slow,
	// Lines driven by the block
	input wire logic [7:0] bus_data_out,
	input wire logic bus_valid_out,
	input wire logic bus_ready_out,
	input wire logic bus_accepted_out,
	// Lines driven by this model
	output logic [7:0] data_low,
	output logic valid,
	output logic ready,
	output logic accepted,
	output logic end_line,
	output logic [7:0] rx_byte,
	output int rx_cnt
);
	logic [3:0] wait_cnt;
	// ==========================================================================
	// Talker: offers a byte only to a ready acceptor and holds it until accepted.
	// Released data lines toggle every cycle so a stale byte cannot pass as valid.
	always_ff @(posedge clk) begin
		if (rst) begin
			valid <= 1'b0;
			end_line <= 1'b0;
			data_low <= 8'h00;
		end else if (!valid && tx_req && bus_ready_out && !bus_accepted_out) begin
			valid <= 1'b1;
			data_low <= tx_byte;
			end_line <= tx_end;
		end else if (valid && bus_accepted_out) begin
			valid <= 1'b0;
			end_line <= 1'b0;
			data_low <= ~data_low;
		end else if (!valid) begin
			data_low <= ~data_low;
		end
	end
	// ==========================================================================
	// Listener: drops ready at once, accepts after a chosen delay, re-arms on release.
	always_ff @(posedge clk) begin
		if (rst) begin
			ready <= 1'b1;
			accepted <= 1'b0;
			wait_cnt <= 4'h0;
			rx_byte <= 8'h00;
			rx_cnt <= 0;
		end else if (bus_valid_out && !accepted) begin
			ready <= 1'b0;
			wait_cnt <= wait_cnt + 4'h1;
			if (wait_cnt >= slow) begin
				accepted <= 1'b1;
				rx_byte <= bus_data_out;
				rx_cnt <= rx_cnt + 1;
				wait_cnt <= 4'h0;
			end
		end else if (!bus_valid_out && accepted) begin
			accepted <= 1'b0;
			ready <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench: AXI4-Lite register tasks and the far-side bus model.
// Assumes one 20 MHz clock and the register map of the block's package.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic awready;
	logic [31:0] wdata = 32'h0;
	logic wvalid = 1'b0;
	logic wready;
	logic [1:0] bresp;
	logic bvalid;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic arready;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic rvalid;
	logic rready = 1'b0;
	logic att = 1'b0;
	logic tx_req = 1'b0;
	logic [7:0] tx_byte = 8'h00;
	logic tx_end = 1'b0;
	logic [3:0] slow = 4'h0;
	logic [7:0] fdata, dout, frx;
	logic fvalid, fready, facc, fend, doe, dvalid, dready, dacc, irq;
	int frx_cnt;
	int n_fail = 0;
	int cmp_count = 0;
	logic [31:0] d;
	logic [1:0] r;
	// ==========================================================================
	// Clock at 50 ns period and the two parties.
	always #25 clk = ~clk;
	bhht_top dut (.clk(clk), .rst(rst), .ce(1'b1),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.bus_data_low_in(fdata), .bus_valid_in(fvalid), .bus_ready_in(fready),
		.bus_accepted_in(facc), .bus_attention_in(att), .bus_end_in(fend),
		.bus_data_out(dout), .bus_data_oe(doe), .bus_valid_out(dvalid),
		.bus_ready_out(dready), .bus_accepted_out(dacc), .irq(irq));
	bhht_far far (.clk(clk), .rst(rst), .tx_req(tx_req), .tx_byte(tx_byte), .tx_end(tx_end),
		.slow(slow), .bus_data_out(dout), .bus_valid_out(dvalid), .bus_ready_out(dready),
		.bus_accepted_out(dacc), .data_low(fdata), .valid(fvalid), .ready(fready),
		.accepted(facc), .end_line(fend), .rx_byte(frx), .rx_cnt(frx_cnt));
	// ==========================================================================
	// Verdict, comparison and timeout handling.
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tmo();
		n_fail++;
		$display("BAD at %0t seen %h expected %h", $time, 32'h0, 32'h1);
		report_and_stop();
	endtask
	// Overall watchdog in case a bus task never sees its answer.
	initial begin
		#2000000;
		tmo();
	end
	// ==========================================================================
	// AXI4-Lite master: payload held until each channel's ready is sampled.
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		if (n == 100) tmo();
		bready <= 1'b0;
		chk(32'(bresp), 32'(bhht_pkg::RESP_OKAY));
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		if (n == 100) tmo();
		rready <= 1'b0;
		v = rdata;
		rr = rresp;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] e);
		rd(a, d, r);
		chk(d & mk, e);
	endtask
	// Helpers for waits, modes and whole bytes from the far talker.
	task automatic wt(ref logic s, input logic v);
		int n;
		for (n = 0; n < 300 && s !== v; n++) @(posedge clk);
		if (s !== v) tmo();
	endtask
	task automatic pst(input int b);
		int n;
		for (n = 0; n < 60; n++) begin
			rd(bhht_pkg::ADDR_INT_STATUS, d, r);
			if (d[b] === 1'b1) break;
		end
		if (n == 60) tmo();
	endtask
	task automatic md(input logic [3:0] m);
		wr(bhht_pkg::ADDR_ADDR_MODE, (32'(m[0]) << bhht_pkg::MODE_HOLD_ALL) |
			(32'(m[1]) << bhht_pkg::MODE_HOLD_END) | (32'(m[2]) << bhht_pkg::MODE_TALK_ONLY) |
			(32'(m[3]) << bhht_pkg::MODE_LISTEN_ONLY));
	endtask
	task automatic sb(input logic [7:0] b, input logic e);
		tx_byte <= b;
		tx_end <= e;
		tx_req <= 1'b1;
		wt(fvalid, 1'b1);
		tx_req <= 1'b0;
	endtask
	task automatic got(input logic [7:0] b);
		pst(bhht_pkg::ST_BYTE_RECEIVED);
		rd_chk(bhht_pkg::ADDR_DATA, 32'hff, {24'h0, b});
		wt(fvalid, 1'b0);
	endtask
	// ==========================================================================
	// Main sequence.
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd_chk(bhht_pkg::ADDR_INT_STATUS, 32'h1, 32'h0);
		rd_chk(bhht_pkg::ADDR_AUX_CMD, 32'hffffffff, 32'h0);
		rd(8'h18, d, r);
		chk(32'(r), 32'(bhht_pkg::RESP_SLVERR));
		chk(32'(irq), 32'h0);
		$display("test reset done");
		// Listener path, interrupt mask and host read release.
		md(4'b1000);
		wt(dready, 1'b1);
		sb(8'h5a, 1'b0);
		pst(bhht_pkg::ST_BYTE_RECEIVED);
		chk(32'(irq), 32'h0);
		rd_chk(bhht_pkg::ADDR_HS_STATUS, 32'h9, 32'h1);
		chk(32'(doe), 32'h0);
		wr(bhht_pkg::ADDR_INT_MASK, 32'h1);
		repeat (3) @(posedge clk);
		chk(32'(irq), 32'h1);
		chk(32'(fvalid), 32'h1);
		got(8'h5a);
		rd_chk(bhht_pkg::ADDR_INT_STATUS, 32'h1, 32'h0);
		chk(32'(irq), 32'h0);
		$display("test listen done");
		// Command byte under attention, released by the accept-release command.
		wt(dacc, 1'b0);
		att <= 1'b1;
		sb(8'h3f, 1'b0);
		pst(bhht_pkg::ST_BYTE_RECEIVED);
		rd_chk(bhht_pkg::ADDR_INT_STATUS, 32'h8, 32'h8);
		rd_chk(bhht_pkg::ADDR_HS_STATUS, 32'h9, 32'h9);
		wr(bhht_pkg::ADDR_AUX_CMD, 32'h1 << bhht_pkg::AUX_ACCEPT_RELEASE);
		wt(fvalid, 1'b0);
		rd_chk(bhht_pkg::ADDR_DATA, 32'hff, 32'h3f);
		att <= 1'b0;
		$display("test attention done");
		// Hold-off on every byte blocks the next transfer until ready-release.
		md(4'b1001);
		sb(8'h11, 1'b0);
		got(8'h11);
		tx_byte <= 8'h22;
		tx_req <= 1'b1;
		repeat (20) @(posedge clk);
		chk(32'(dready), 32'h0);
		chk(32'(fvalid), 32'h0);
		md(4'b1000);
		wr(bhht_pkg::ADDR_AUX_CMD, 32'h1 << bhht_pkg::AUX_READY_RELEASE);
		wt(fvalid, 1'b1);
		tx_req <= 1'b0;
		got(8'h22);
		$display("test hold all done");
		// Hold-off on end only engages after the end-marked byte.
		md(4'b1010);
		sb(8'h33, 1'b0);
		got(8'h33);
		wt(dready, 1'b1);
		sb(8'h44, 1'b1);
		pst(bhht_pkg::ST_BYTE_RECEIVED);
		rd_chk(bhht_pkg::ADDR_INT_STATUS, 32'h4, 32'h4);
		got(8'h44);
		repeat (20) @(posedge clk);
		chk(32'(dready), 32'h0);
		md(4'b1000);
		wr(bhht_pkg::ADDR_AUX_CMD, 32'h1 << bhht_pkg::AUX_READY_RELEASE);
		wt(dready, 1'b1);
		$display("test hold end done");
		// A byte written while listening waits, then goes out as talk-only source.
		slow <= 4'h4;
		wr(bhht_pkg::ADDR_INT_MASK, 32'h2);
		wr(bhht_pkg::ADDR_DATA, 32'hc3);
		repeat (20) @(posedge clk);
		chk(32'(frx_cnt), 32'h0);
		md(4'b0100);
		pst(bhht_pkg::ST_BYTE_SENT);
		chk(32'(frx_cnt), 32'h1);
		chk({24'h0, frx}, 32'hc3);
		chk(32'(irq), 32'h1);
		wr(bhht_pkg::ADDR_DATA, 32'ha5);
		wt(facc, 1'b1);
		chk({24'h0, frx}, 32'ha5);
		chk(32'(doe), 32'h1);
		pst(bhht_pkg::ST_BYTE_SENT);
		chk(32'(doe), 32'h0);
		$display("test talk done");
		report_and_stop();
	end
endmodule
`default_nettype wire
